/* File: tb/sps_spi_partner.sv */
// Purpose: far-side SPI device, behavioural
// Assumes: clock idles low
// Notes: changes data on falling edge, samples on rising
`timescale 1ns/100ps
`default_nettype none
module sps_spi_partner
(
	// wires
	input wire logic sck,
	input wire logic sdo,
	output logic sdi,
	// bytes
	input wire logic load,
	input wire logic [7:0] txByte,
	output logic [7:0] rxByte
);
	logic [7:0] sh = 8'h00;
	assign sdi = sh[7];
	always @(posedge sck)
		rxByte = {rxByte[6:0], sdo};
	// refill inverted so stale data never looks valid
	// one process owns the shifter: load wins, else shift on falling sck
	always @(posedge load or negedge sck)
	begin
		if (load)
			sh = txByte;
		else
			sh = {sh[6:0], ~sh[7]};
	end
endmodule
`default_nettype wire

/* File: tb/sps_spi_port_assertions.sv */
// Purpose: port checks of the SPI port
// Assumes: control writes are seen on the APB pins
// Notes: mode, enable and polarity are shadowed from bus writes
`timescale 1ns/100ps
`default_nettype none
module sps_spi_port_assertions
	import sps_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	// pins and flag
	input wire sps_pin_in_t pinIn,
	input wire sps_pin_out_t pinOut,
	input wire logic portIntFlag
);
	// ========
	// control shadow and sck half count
	logic [5:0] sh;
	logic [3:0] tgl;
	logic mst;
	logic sel4;
	logic wr;
	assign wr = psel && penable && pready && pwrite;
	assign mst = sh[5] && sh[3:0] <= 4'h3;
	assign sel4 = sh[5] && sh[3:0] == 4'h4;
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sh <= 6'h00;
			tgl <= 4'h0;
		end
		else
		begin
			if (wr && paddr == OFS_CTRL)
				sh <= pwdata[5:0];
			// two-cycle window hides a polarity step
			if (!mst || $past(sh, 2) != sh)
				tgl <= 4'h0;
			else if ($changed(pinOut.sckOut))
				tgl <= tgl + 4'h1;
		end
	end

	// ========
	// assertions
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	sck_dir_a: assert property (
		$stable(sh) |-> pinOut.sckOeN == !mst)
		else $error("sck direction wrong for mode");
	idle_codes_a: assert property (
		$stable(sh) && !(sh[5] && sh[3:0] <= 4'h5) |-> pinOut.sdoOeN)
		else $error("data out driven while idle");
	ss_free_a: assert property (
		$stable(sel4) |-> pinOut.ssPinFree == !sel4)
		else $error("slave select use wrong");
	ss_gate_a: assert property (
		(sel4 && pinIn.ssN) [*6] |-> pinOut.sdoOeN && !$rose(portIntFlag))
		else $error("deselected slave active");
	idle_level_a: assert property (
		mst && $stable(sh) && tgl == 4'h0 && !$changed(pinOut.sckOut)
		|-> pinOut.sckOut == sh[4])
		else $error("clock idle level wrong");
	full_byte_a: assert property (
		mst && $rose(portIntFlag) |-> tgl >= 4'hE || tgl == 4'h0)
		else $error("byte done at wrong clock count");
	bit_rate_a: assert property (
		mst && sh[3:0] == 4'h1 && $stable(sh) && $changed(pinOut.sckOut)
		|=> $stable(pinOut.sckOut) [*7])
		else $error("half period too short");
	int_sticky_a: assert property (
		$fell(portIntFlag) |-> $past(wr && paddr == OFS_STAT, 1)
		|| $past(wr && paddr == OFS_STAT, 2))
		else $error("flag fell without a clear");
endmodule

bind sps_spi_port sps_spi_port_assertions i_chk (.clk_sys, .arst_n,
	.psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pinIn,
	.pinOut, .portIntFlag);
`default_nettype wire

/* File: tb/tb_top.sv */
// Purpose: self-checking bench of the SPI port
// Assumes: clock idles low, cke set
// Notes: fast master input not compared, pin sync too slow
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import sps_pkg::*;
;
	logic clk_sys, arst_n, psel, penable, pwrite, pready, pslverr;
	logic tmr = 1'b0;
	logic portIntFlag, tbSck, ssN, load, er, sckW, sdiW;
	logic [7:0] paddr, txB, rxB, tx;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] tc = 4'h0;
	sps_pin_in_t pinIn;
	sps_pin_out_t pinOut;
	int failures, total_checks, seed, m;

	// ========
	// clock, timer, pins
	always #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		tc <= tc + 4'h1;
		tmr <= tc == 4'h0;
	end
	assign sckW = pinOut.sckOeN ? tbSck : pinOut.sckOut;
	assign pinIn = {sckW, sdiW, ssN};
	sps_spi_port i_dut (.clk_sys, .arst_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr,
		.timerTwoPulse(tmr), .pinIn, .pinOut, .portIntFlag);
	sps_spi_partner i_far (.sck(sckW), .sdi(sdiW), .load,
		.sdo(pinOut.sdoOeN ? ~rxB[0] : pinOut.sdoOut),
		.txByte(txB), .rxByte(rxB));

	// ========
	// tasks
	task automatic chk(input string n, input logic [31:0] s, e);
		total_checks++;
		if (s !== e)
		begin
			failures++;
			$display("mismatch %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			failures++;
			tally_and_finish();
		end
		@(posedge clk_sys);
	endtask
	task automatic xfer(input logic [7:0] c, input logic s, input logic e);
		int n = 0;
		txB <= 8'($random(seed));
		tx = 8'($random(seed));
		ssN <= s;
		apb(1'b1, OFS_CTRL, 32'h0);
		load <= 1'b1;
		apb(1'b1, OFS_CTRL, {24'h0, c});
		load <= 1'b0;
		apb(1'b1, OFS_BUF, {24'h0, tx});
		if (c[3:0] > 4'h3)
		begin
			repeat (16)
			begin
				repeat (10) @(posedge clk_sys);
				tbSck <= ~tbSck;
			end
			repeat (10) @(posedge clk_sys);
		end
		else
			apb(1'b1, OFS_BUF, {24'h0, ~tx});
		// bounded poll; a slow byte fails rather than hangs
		do
		begin
			apb(1'b0, OFS_STAT, 32'h0);
			n++;
		end
		while (e && rd[0] !== 1'b1 && n < 300);
		chk("full", rd[0], e);
		apb(1'b0, OFS_CTRL, 32'h0);
		chk("coll", rd[7], c[3:0] < 4'h4);
		if (e)
		begin
			chk("out", rxB, tx);
			apb(1'b0, OFS_BUF, 32'h0);
			if (c[3:0] != 4'h0)
				chk("in", rd[7:0], txB);
			chk("flag", portIntFlag, 1'b1);
			apb(1'b1, OFS_STAT, 32'h42);
		end
	endtask

	// ========
	// main sequence
	initial
	begin
		{clk_sys, arst_n, psel, penable, pwrite, tbSck, load} = 7'h00;
		{paddr, pwdata, txB} = 48'h0;
		ssN = 1'b1;
		failures = 0;
		total_checks = 0;
		seed = 32'hF8280019;
		repeat (16) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		apb(1'b0, OFS_CTRL, 32'h0);
		chk("ctrl", rd, {24'h0, CTRL_RST});
		apb(1'b0, 8'h0C, 32'h0);
		chk("unmapped", {er, rd[30:0]}, 32'h80000000);
		apb(1'b1, OFS_STAT, 32'h40);
		for (m = 0; m < 4; m++)
			xfer(8'h20 | 8'(m), 1'b1, 1'b1);
		// late sampling: master samples on falling edges, byte must agree
		apb(1'b1, OFS_STAT, 32'hC0);
		xfer(8'h21, 1'b1, 1'b1);
		xfer(8'h24, 1'b0, 1'b1);
		xfer(8'h25, 1'b1, 1'b1);
		xfer(8'h24, 1'b1, 1'b0);
		for (m = 6; m < 16; m++)
			xfer(8'h20 | 8'(m), 1'b0, 1'b0);
		tally_and_finish();
	end
endmodule
`default_nettype wire

/* File: verilog/sps_pin_sync.sv */
// Purpose: three-stage synchroniser with agreement filter for pins
// Assumes: inputs asynchronous to clk_sys
// Notes: output follows once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module sps_pin_sync
#(
	parameter int W = 3
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// pins
	input wire logic [W-1:0] pinAsync,
	// filtered levels
	output logic [W-1:0] pinClean
);

	// ==========================================================
	// elaboration check
	generate
		if (W < 1)
		begin : g_bad
			$error("sps_pin_sync: W must be at least 1");
		end
	endgenerate

	// ==========================================================
	// state
	typedef struct packed
	{
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] filt;
	} sps_sync_t;

	sps_sync_t sync_reg;
	sps_sync_t sync_next;

	// stage one feeds only stage two
	always_comb
	begin
		sync_next = sync_reg;
		sync_next.s1 = pinAsync;
		sync_next.s2 = sync_reg.s1;
		sync_next.s3 = sync_reg.s2;
		for (int i = 0; i < W; i++)
		begin
			if (sync_reg.s2[i] == sync_reg.s3[i])
			begin
				sync_next.filt[i] = sync_reg.s3[i];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync_reg <= '0;
		end
		else
		begin
			sync_reg <= sync_next;
		end
	end

	assign pinClean = sync_reg.filt;

endmodule
`default_nettype wire

/* File: verilog/sps_pkg.sv */
// Purpose: shared constants and types of the serial port in SPI mode
// Assumes: 32-bit APB register window, 20 MHz system clock
// Notes: bit positions refer to the 8-bit registers in the low byte
package sps_pkg;

	// ==========================================================
	// register map
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_BUF = 8'h08;

	// ==========================================================
	// serial_port_control fields
	localparam int CTRL_WRITE_COLLISION_FLAG = 7;
	localparam int CTRL_OVF = 6;
	localparam int CTRL_EN = 5;
	localparam int CTRL_CKP = 4;
	localparam logic [7:0] CTRL_RST = 8'h00;

	// ==========================================================
	// serial_port_status fields
	localparam int STAT_SMP = 7;
	localparam int STAT_CKE = 6;
	localparam int STAT_IF = 1;
	localparam int STAT_BF = 0;

	// ==========================================================
	// port_mode_select codes
	localparam logic [3:0] MODE_M_DIV4 = 4'h0;
	localparam logic [3:0] MODE_M_DIV16 = 4'h1;
	localparam logic [3:0] MODE_M_DIV64 = 4'h2;
	localparam logic [3:0] MODE_M_TMR = 4'h3;
	localparam logic [3:0] MODE_S_SEL = 4'h4;
	localparam logic [3:0] MODE_S_FREE = 4'h5;

	// ==========================================================
	// timing: bit rate divisors of the system clock, half periods
	localparam int CLK_HZ = 20000000;
	localparam logic [5:0] HALF_DIV4 = 6'(4 / 2 - 1);
	localparam logic [5:0] HALF_DIV16 = 6'(16 / 2 - 1);
	localparam logic [5:0] HALF_DIV64 = 6'(64 / 2 - 1);
	localparam logic [3:0] LAST_HALF = 4'hF;
	localparam logic [3:0] LAST_BIT = 4'h7;

	// ==========================================================
	// engine states
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_MRUN = 3'b010,
		ST_SRUN = 3'b100
	} sps_fsm_t;

	// ==========================================================
	// pin carriers
	typedef struct packed
	{
		logic sck;
		logic sdi;
		logic ssN;
	} sps_pin_in_t;

	typedef struct packed
	{
		logic sckOut;
		logic sckOeN;
		logic sdoOut;
		logic sdoOeN;
		logic ssPinFree;
	} sps_pin_out_t;

endpackage

/* File: verilog/sps_spi_port.sv */
// Purpose: serial port mode select and SPI engine with APB registers
// Assumes: timer-two output arrives as a one-cycle pulse on clk_sys
// Notes: I2C codes and reserved codes leave the SPI engine idle
//
// Behaviour
// - codes 0..3 select master; clock Fosc/4, /16, /64 or timer_two/2
// - code 4 selects slave on SCK with slave select controlling transfer
// - code 5 selects slave on SCK, slave select ignored, pin free
// - codes 6, 7, B, E, F belong to I2C functions, not SPI
// - eight bits go out and come in at the same time
// - all four polarity/phase modes; late sampling in master only and only with cke set
// - data out, data in and serial clock pins carry SPI
// - slave select pin only serves in slave mode
// - master drives SCK out; slave takes SCK in
// - clock_idle_polarity sets SCK idle level
// - edge select sets which SCK edge changes output data
// - sample select sets input sampling phase
// - bit rate choice applies in master only
// - slave select gating only in slave mode
// - port works only while enabled; clearing enable resets the engine
// - MSB first; after eight bits load buffer (kept if unread in slave mode, overflow set), set full and int flags
// - buffer write during transfer is dropped and collision flag set
// - slave select high stops data output and resets bit counter
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module sps_spi_port
	import sps_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// timer-two output pulse
	input wire logic timerTwoPulse,
	// serial pins
	input wire sps_pin_in_t pinIn,
	output sps_pin_out_t pinOut,
	// flag levels
	output logic portIntFlag
);

	// ==========================================================
	// elaboration check
	generate
		if (ADDR_W < 8)
		begin : g_bad
			$error("sps_spi_port: ADDR_W must be at least 8");
		end
	endgenerate

	// ==========================================================
	// state
	typedef struct packed
	{
		sps_fsm_t fsm;
		logic [7:0] ctrl;
		logic smp;
		logic cke;
		logic intf;
		logic bf;
		logic [7:0] rxBuf;
		logic [7:0] txSh;
		logic [7:0] rxSh;
		logic [3:0] half;
		logic [3:0] samp;
		logic [5:0] div;
		logic sckLast;
		logic sckOut;
		logic sckOeN;
		logic sdoOeN;
		logic ssFree;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} sps_state_t;

	sps_state_t st_reg;
	sps_state_t st_next;

	// ==========================================================
	// pin synchroniser
	sps_pin_in_t pinSync;

	sps_pin_sync #(
		.W(3)
	) u_sync (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.pinAsync(pinIn),
		.pinClean(pinSync)
	);

	// ==========================================================
	// decoded control
	logic portEn;
	logic [3:0] modeSel;
	logic isMaster;
	logic isSlave;
	logic ssGate;
	logic [5:0] halfLen;

	always_comb
	begin
		portEn = st_reg.ctrl[CTRL_EN];
		modeSel = st_reg.ctrl[3:0];
		// master codes 0..3
		isMaster = portEn && (modeSel <= MODE_M_TMR);
		// slave codes 4 and 5
		isSlave = portEn && ((modeSel == MODE_S_SEL) ||
			(modeSel == MODE_S_FREE));
		// I2C and reserved codes fall in neither; engine stays idle
		ssGate = isSlave && (modeSel == MODE_S_SEL) && pinSync.ssN;
		if (modeSel == MODE_M_DIV16)
		begin
			halfLen = HALF_DIV16;
		end
		else if (modeSel == MODE_M_DIV64)
		begin
			halfLen = HALF_DIV64;
		end
		else
		begin
			halfLen = HALF_DIV4;
		end
	end

	// ==========================================================
	// next state
	logic apbSetup;
	logic apbDone;
	logic wrCtrl;
	logic wrStat;
	logic wrBuf;
	logic rdBuf;
	logic tick;
	logic sckEdge;
	logic step;
	logic doShift;
	logic doSamp;
	logic byteDone;
	logic busy;
	logic [3:0] k;

	always_comb
	begin
		st_next = st_reg;
		apbSetup = psel && !penable;
		apbDone = psel && penable && st_reg.pready && !st_reg.pslverr;
		wrCtrl = apbDone && pwrite && (paddr[7:0] == OFS_CTRL);
		wrStat = apbDone && pwrite && (paddr[7:0] == OFS_STAT);
		wrBuf = apbDone && pwrite && (paddr[7:0] == OFS_BUF);
		rdBuf = apbDone && !pwrite && (paddr[7:0] == OFS_BUF);
		tick = 1'b0;
		sckEdge = 1'b0;
		step = 1'b0;
		doShift = 1'b0;
		doSamp = 1'b0;
		byteDone = 1'b0;
		k = st_reg.half;
		busy = (st_reg.fsm == ST_MRUN) || (st_reg.half != 4'h0);

		// apb: one wait state, data and error set up in setup phase
		st_next.pready = psel && penable && !st_reg.pready;
		if (apbSetup)
		begin
			st_next.pslverr = 1'b0;
			st_next.prdata = 32'h0000_0000;
			if (paddr[7:0] == OFS_CTRL)
			begin
				st_next.prdata[7:0] = st_reg.ctrl;
			end
			else if (paddr[7:0] == OFS_STAT)
			begin
				st_next.prdata[STAT_SMP] = st_reg.smp;
				st_next.prdata[STAT_CKE] = st_reg.cke;
				st_next.prdata[STAT_IF] = st_reg.intf;
				st_next.prdata[STAT_BF] = st_reg.bf;
			end
			else if (paddr[7:0] == OFS_BUF)
			begin
				st_next.prdata[7:0] = st_reg.rxBuf;
			end
			else
			begin
				st_next.pslverr = 1'b1;
			end
		end

		// software writes; flags clear only, hardware sets win below
		if (wrCtrl)
		begin
			st_next.ctrl[5:0] = pwdata[5:0];
			st_next.ctrl[CTRL_WRITE_COLLISION_FLAG] = st_reg.ctrl[CTRL_WRITE_COLLISION_FLAG] &
				pwdata[CTRL_WRITE_COLLISION_FLAG];
			st_next.ctrl[CTRL_OVF] = st_reg.ctrl[CTRL_OVF] &
				pwdata[CTRL_OVF];
		end
		if (wrStat)
		begin
			st_next.smp = pwdata[STAT_SMP];
			st_next.cke = pwdata[STAT_CKE];
			if (pwdata[STAT_IF])
			begin
				st_next.intf = 1'b0;
			end
		end
		if (rdBuf)
		begin
			st_next.bf = 1'b0;
		end

		// buffer write while shifting is dropped
		if (wrBuf && busy)
		begin
			st_next.ctrl[CTRL_WRITE_COLLISION_FLAG] = 1'b1;
		end

		// master bit-rate tick
		if (modeSel == MODE_M_TMR)
		begin
			tick = timerTwoPulse;
		end
		else if (st_reg.div == halfLen)
		begin
			tick = 1'b1;
		end
		if (st_reg.fsm == ST_MRUN)
		begin
			st_next.div = tick ? 6'h00 : 6'(st_reg.div + 6'h01);
		end

		// slave sees filtered SCK edges only
		st_next.sckLast = pinSync.sck;
		sckEdge = pinSync.sck != st_reg.sckLast;

		case (st_reg.fsm)
			ST_IDLE:
			begin
				st_next.sckOut = st_reg.ctrl[CTRL_CKP];
				if (isMaster && wrBuf && !busy)
				begin
					// writing the buffer starts a master byte
					st_next.txSh = pwdata[7:0];
					st_next.half = 4'h0;
					st_next.samp = 4'h0;
					st_next.div = 6'h00;
					st_next.fsm = ST_MRUN;
				end
				else if (isSlave && wrBuf && !busy)
				begin
					st_next.txSh = pwdata[7:0];
				end
				if (isSlave && !ssGate && sckEdge)
				begin
					step = 1'b1;
					st_next.fsm = ST_SRUN;
				end
			end
			ST_MRUN:
			begin
				if (tick)
				begin
					step = 1'b1;
					st_next.sckOut = !st_reg.sckOut;
				end
			end
			ST_SRUN:
			begin
				if (sckEdge && !ssGate)
				begin
					step = 1'b1;
				end
			end
			default:
			begin
				st_next.fsm = ST_IDLE;
			end
		endcase

		// edge k: cke=1 shifts on odd edges, cke=0 on even edges past 0
		if (step)
		begin
			doShift = (k[0] == st_reg.cke) && (k != 4'h0);
			if (isMaster && st_reg.smp && st_reg.cke)
			begin
				// late sample at the end of the data output time
				doSamp = k[0];
			end
			else
			begin
				doSamp = k[0] != st_reg.cke;
			end
			if (doShift)
			begin
				st_next.txSh = {st_reg.txSh[6:0], 1'b0};
			end
			if (doSamp)
			begin
				st_next.rxSh = {st_reg.rxSh[6:0], pinSync.sdi};
				st_next.samp = 4'(st_reg.samp + 4'h1);
				byteDone = st_reg.samp == LAST_BIT;
			end
			st_next.half = 4'(k + 4'h1);
			if (k == LAST_HALF)
			begin
				st_next.fsm = ST_IDLE;
				st_next.half = 4'h0;
				st_next.samp = 4'h0;
				st_next.sckOut = st_reg.ctrl[CTRL_CKP];
			end
		end

		// received byte goes to the buffer unless, in slave mode, the last is unread
		if (byteDone)
		begin
			st_next.intf = 1'b1;
			if (isSlave && st_reg.bf && !rdBuf)
			begin
				st_next.ctrl[CTRL_OVF] = 1'b1;
			end
			else
			begin
				st_next.rxBuf = {st_reg.rxSh[6:0], pinSync.sdi};
				st_next.bf = 1'b1;
			end
		end

		// disable, wrong mode or raised select resets the counters
		if (!(isMaster || isSlave) || ssGate)
		begin
			st_next.fsm = ST_IDLE;
			st_next.half = 4'h0;
			st_next.samp = 4'h0;
			st_next.sckOut = st_reg.ctrl[CTRL_CKP];
		end
		if (isMaster && (st_reg.fsm == ST_SRUN))
		begin
			// mode changed mid-byte
			st_next.fsm = ST_IDLE;
			st_next.half = 4'h0;
			st_next.samp = 4'h0;
		end

		// pin drive; no driving at all outside the SPI codes
		st_next.sckOeN = !isMaster;
		st_next.sdoOeN = !(isMaster || (isSlave && !ssGate));
		st_next.ssFree = !(isSlave && (modeSel == MODE_S_SEL));
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_reg <= '0;
			st_reg.fsm <= ST_IDLE;
			st_reg.ctrl <= CTRL_RST;
			st_reg.sckOeN <= 1'b1;
			st_reg.sdoOeN <= 1'b1;
			st_reg.ssFree <= 1'b1;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// outputs straight from the state register
	assign prdata = st_reg.prdata;
	assign pready = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign pinOut.sckOut = st_reg.sckOut;
	assign pinOut.sckOeN = st_reg.sckOeN;
	assign pinOut.sdoOut = st_reg.txSh[7];
	assign pinOut.sdoOeN = st_reg.sdoOeN;
	assign pinOut.ssPinFree = st_reg.ssFree;
	assign portIntFlag = st_reg.intf;

endmodule
`default_nettype wire
